// File: design/ssf_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.vh"

module ssf_monitor (
  input  wire        core_clk,          // Core clock, 10 MHz
  input  wire        srst,              // Arming machine reset, sync, active high
  input  wire        safing_mode,       // Arming machine is in Safing mode
  input  wire        startup_mode,      // Arming machine is in Start-up mode
  input  wire        spi_sck,           // Snooped serial clock pin
  input  wire        spi_miso,          // Snooped reply data pin
  input  wire        cs_main_n,         // Main chip select, active low
  input  wire        onboard_pick_one_n,   // Chip select one, active low
  input  wire        onboard_pick_two_n,   // Chip select two, active low
  input  wire        expansion_pick_three_n, // Chip select three, active low
  input  wire        period_sync,       // Sampling period sync pin
  input  wire        limit_key_cmd,     // Pulse: key write command decoded
  input  wire        limit_write_cmd,   // Pulse: limit write command decoded
  input  wire        other_cmd,         // Pulse: any other command decoded
  input  wire [7:0]  cmd_data,          // Data field of the decoded command
  input  wire [2:0]  limit_index,       // Limit addressed by write or read
  input  wire        smp_ready,         // Drain side takes a buffered sample
  output reg         frame_qualified_q, // Pulse: qualified sensor frame
  output reg         order_mismatch_q,  // Pulse: order tag mismatch
  output reg         order_fault_bit_q, // Level: fault held until period sync
  output reg         sample_ok_q,       // Pulse: valid in-range sample
  output reg  [3:0]  valid_count_q,     // Valid samples this period
  output reg  [8:0]  cmp_limit_q,       // Magnitude limit for last sample
  output reg         cmp_dwell_long_q,  // Last sample limit asks for long dwell
  output reg  [7:0]  limit_rd_q,        // Stored limit at limit_index
  output reg         limit_wr_done_q,   // Pulse: limit write accepted
  output reg         sample_drop_q,     // Pulse: sample lost, buffer full
  output wire        buf_ready,         // Buffer can take a sample
  output wire        smp_valid,         // Buffered sample present
  output wire [13:0] smp_data           // {order position, sample value}
);

  // Synchronisers: stage one, stage two, and a third for edge finding
  reg  [6:0]  sync1_q;
  reg  [6:0]  sync2_q;
  reg  [6:0]  sync3_q;
  wire [6:0]  pins_raw;
  wire [3:0]  cs_act;
  wire [3:0]  cs_act_prev;
  wire        any_act;
  wire        any_act_prev;
  wire        multi_now;
  wire        sck_rise;
  wire        ps_rise;
  wire        frame_end;

  // Frame capture
  reg  [4:0]  edge_cnt_q;
  reg  [15:0] shift_q;
  reg         multi_q;

  // Control counters and fault
  reg  [3:0]  order_q;
  reg  [3:0]  base_order;
  reg  [3:0]  next_order;
  reg  [3:0]  base_vcnt;
  reg         base_fault;
  reg         fq_d;
  reg         mism_d;
  reg         in_range;
  reg         sok_d;
  wire [1:0]  reply_kind;
  wire [2:0]  order_tag;
  wire [9:0]  sample_value;

  // Frame and sample qualification terms
  wire        frame_clean;
  wire        frame_long;
  wire        kind_data;
  wire        value_lo_ok;
  wire        value_hi_ok;

  // Limits and key
  reg  [7:0]  limit_q [0:7];
  reg  [7:0]  key_q;
  reg         key_armed_q;
  wire        limit_ok;
  wire [63:0] lim_def;

  wire        buf_in_ready;

  assign pins_raw = {period_sync, expansion_pick_three_n, onboard_pick_two_n,
                     onboard_pick_one_n, cs_main_n, spi_miso, spi_sck};

  always @(posedge core_clk) begin
    if (srst) begin
      sync1_q <= `SSF_SYNC_RST;
      sync2_q <= `SSF_SYNC_RST;
      sync3_q <= `SSF_SYNC_RST;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign cs_act      = ~sync2_q[`SSF_SYNC_CS_HI:`SSF_SYNC_CS_LO];
  assign cs_act_prev = ~sync3_q[`SSF_SYNC_CS_HI:`SSF_SYNC_CS_LO];
  assign any_act      = |cs_act;
  assign any_act_prev = |cs_act_prev;
  assign sck_rise  = sync2_q[`SSF_SYNC_SCK] & ~sync3_q[`SSF_SYNC_SCK];
  assign ps_rise   = sync2_q[`SSF_SYNC_PS] & ~sync3_q[`SSF_SYNC_PS];
  assign frame_end = any_act_prev & ~any_act;
  assign multi_now = (cs_act & (cs_act - 4'h1)) != 4'h0;

  // Sampling MISO on the rising serial clock edge suits the sensors' mode 0
  always @(posedge core_clk) begin
    if (srst) begin
      edge_cnt_q <= 5'h00;
      shift_q    <= 16'h0000;
      multi_q    <= 1'b0;
    end else if (!any_act) begin
      edge_cnt_q <= 5'h00;
      multi_q    <= 1'b0;
    end else begin
      if (multi_now) begin
        multi_q <= 1'b1;
      end
      if (sck_rise && edge_cnt_q < `SSF_FRAME_BITS) begin
        shift_q    <= {shift_q[14:0], sync2_q[`SSF_SYNC_MISO]};
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
    end
  end

  assign reply_kind   = shift_q[`SSF_KIND_HI:`SSF_KIND_LO];
  assign order_tag    = shift_q[`SSF_TAG_HI:`SSF_TAG_LO];
  assign sample_value = shift_q[`SSF_VAL_HI:`SSF_VAL_LO];

  assign frame_clean = frame_end & ~multi_q;
  assign frame_long  = (edge_cnt_q >= `SSF_FRAME_BITS);
  assign kind_data   = (reply_kind == `SSF_KIND_DATA);

  // signed window bounds
  // Both bounds are inclusive; the low bound is the two's complement of 480
  assign value_lo_ok = ($signed(sample_value) >= $signed(`SSF_RANGE_LO));
  assign value_hi_ok = ($signed(sample_value) <= $signed(`SSF_RANGE_HI));

  // A frame ending on the period sync edge belongs to the new period
  always @* begin
    base_order = ps_rise ? `SSF_ORDER_RST : order_q;
    base_vcnt  = ps_rise ? `SSF_VCNT_RST : valid_count_q;
    base_fault = ps_rise ? 1'b0 : order_fault_bit_q;
    next_order = base_order + 4'h1;
    fq_d = safing_mode & frame_clean & frame_long &
           (base_order != `SSF_ORDER_FROZEN);
    mism_d = fq_d & (order_tag != next_order[2:0]);
    if (next_order > `SSF_RANGE_ORDER) begin
      in_range = value_lo_ok & value_hi_ok;
    end else begin
      in_range = 1'b1;
    end
    sok_d = fq_d & kind_data & ~(base_fault | mism_d) & in_range;
  end

  always @(posedge core_clk) begin
    if (srst) begin
      order_q           <= `SSF_ORDER_RST;
      valid_count_q     <= `SSF_VCNT_RST;
      order_fault_bit_q <= 1'b0;
      frame_qualified_q <= 1'b0;
      order_mismatch_q  <= 1'b0;
      sample_ok_q       <= 1'b0;
    end else begin
      frame_qualified_q <= fq_d;
      order_mismatch_q  <= mism_d;
      sample_ok_q       <= sok_d;
      order_q <= fq_d ? next_order : base_order;
      if (sok_d && base_order != `SSF_ORDER_FROZEN) begin
        valid_count_q <= base_vcnt + 4'h1;
      end else begin
        valid_count_q <= base_vcnt;
      end
      order_fault_bit_q <= base_fault | mism_d;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      cmp_limit_q      <= 9'h000;
      cmp_dwell_long_q <= 1'b0;
    end else if (sok_d) begin
      cmp_limit_q      <= {2'h0, limit_q[next_order[3:1]][6:0]};
      cmp_dwell_long_q <= limit_q[next_order[3:1]][7];
    end
  end

  assign limit_ok = startup_mode & limit_write_cmd & key_armed_q &
                    (cmd_data == (key_q ^ `SSF_KEY_XOR));

  always @(posedge core_clk) begin
    if (srst) begin
      key_q           <= 8'h00;
      key_armed_q     <= 1'b0;
      limit_wr_done_q <= 1'b0;
      limit_rd_q      <= 8'h00;
    end else begin
      limit_wr_done_q <= limit_ok;
      limit_rd_q      <= limit_q[limit_index];
      // Only the command right after the key may use it
      if (limit_key_cmd) begin
        key_q       <= cmd_data;
        key_armed_q <= 1'b1;
      end else if (limit_write_cmd || other_cmd) begin
        key_armed_q <= 1'b0;
      end
    end
  end

  assign lim_def = `SSF_LIM_DEFAULTS;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_limit
      always @(posedge core_clk) begin
        if (srst) begin
          limit_q[gi] <= lim_def[gi*8 +: 8];
        end else if (limit_ok && limit_index == gi) begin
          limit_q[gi] <= cmd_data;
        end
      end
    end
  endgenerate

  // Sampling cannot stall, so a full buffer costs the sample, not the count
  always @(posedge core_clk) begin
    if (srst) begin
      sample_drop_q <= 1'b0;
    end else begin
      sample_drop_q <= sok_d & ~buf_in_ready;
    end
  end

  assign buf_ready = buf_in_ready;

  ssf_fifo #(
    .WIDTH (`SSF_BUF_WIDTH),
    .DEPTH (`SSF_BUF_DEPTH),
    .AW    (`SSF_BUF_AW)
  ) u_buf (
    .clk         (core_clk),
    .rst         (srst),
    .in_valid    (sok_d),
    .in_ready_q  (buf_in_ready),
    .in_data     ({next_order, sample_value}),
    .out_valid_q (smp_valid),
    .out_ready   (smp_ready),
    .out_data_q  (smp_data)
  );

  // count readback
  // valid_count_q is the field the control command reply carries.
  // It is a plain level, so the command decoder may sample it at any
  // time; a reply taken mid-frame simply misses the frame in flight.

endmodule

`default_nettype wire

// File: design/ssf_defs.vh
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

// Synchroniser idle value: {period_sync, cs3, cs2, cs1, cs0, miso, sck}
`define SSF_SYNC_RST      7'h3C
`define SSF_SYNC_SCK      0
`define SSF_SYNC_MISO     1
`define SSF_SYNC_CS_LO    2
`define SSF_SYNC_CS_HI    5
`define SSF_SYNC_PS       6

// Frame geometry
`define SSF_FRAME_BITS    5'h10
`define SSF_KIND_HI       15
`define SSF_KIND_LO       14
`define SSF_TAG_HI        13
`define SSF_TAG_LO        11
`define SSF_VAL_HI        9
`define SSF_VAL_LO        0
`define SSF_KIND_DATA     2'h1

// Control counters
`define SSF_ORDER_RST     4'hF
`define SSF_ORDER_FROZEN  4'hE
`define SSF_VCNT_RST      4'h0
`define SSF_RANGE_ORDER   4'h2
`define SSF_RANGE_LO      10'h220
`define SSF_RANGE_HI      10'h1E0

// Limit storage, entry 7 in the top byte
`define SSF_LIM_DEFAULTS  64'h040408080808950D
`define SSF_KEY_XOR       8'hAD

// Sample buffer
`define SSF_BUF_WIDTH     14
`define SSF_BUF_DEPTH     16
`define SSF_BUF_AW        4

`endif

// File: design/ssf_fifo.v
`timescale 1ns/1ps
`default_nettype none

module ssf_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,        // Core clock
  input  wire             rst,        // Synchronous reset, active high
  input  wire             in_valid,   // Write request
  output reg              in_ready_q, // Room for one more word
  input  wire [WIDTH-1:0] in_data,    // Write word
  output reg              out_valid_q,// Output word present
  input  wire             out_ready,  // Drain side accepts word
  output reg  [WIDTH-1:0] out_data_q  // Output word
);

  localparam [AW:0] FULL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  wire            push;
  wire            load;

  assign push = in_valid & in_ready_q;
  // Output stage refills whenever memory holds a word and the stage is empty or being drained
  assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @* begin
    cnt_d = cnt_q;
    if (push & ~load) begin
      cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
    end else if (load & ~push) begin
      cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_q    <= {AW{1'b0}};
      rd_ptr_q    <= {AW{1'b0}};
      cnt_q       <= {(AW+1){1'b0}};
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q  <= {WIDTH{1'b0}};
    end else begin
      cnt_q      <= cnt_d;
      in_ready_q <= (cnt_d != FULL);
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (load) begin
        rd_ptr_q    <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q  <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/ssf_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_monitor_props (
  input wire logic        core_clk,          // Clock
  input wire logic        srst,              // Reset
  input wire logic        safing_mode,       // Safing level
  input wire logic        startup_mode,      // Start-up level
  input wire logic        period_sync,       // Period pin
  input wire logic        limit_write_cmd,   // Write pulse
  input wire logic [7:0]  cmd_data,          // Command data
  input wire logic [2:0]  limit_index,       // Limit select
  input wire logic        smp_ready,         // Drain accept
  input wire logic        frame_qualified_q, // Frame pulse
  input wire logic        order_mismatch_q,  // Mismatch pulse
  input wire logic        order_fault_bit_q, // Fault level
  input wire logic        sample_ok_q,       // Sample pulse
  input wire logic [3:0]  valid_count_q,     // Valid count
  input wire logic [7:0]  limit_rd_q,        // Readback
  input wire logic        limit_wr_done_q,   // Write done
  input wire logic        sample_drop_q,     // Drop pulse
  input wire logic        smp_valid,         // Word present
  input wire logic [13:0] smp_data           // Word
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  mismatch_fault_a: assert property (
    order_mismatch_q |-> frame_qualified_q && order_fault_bit_q) else $error("bad mismatch");
  sample_gate_a: assert property (
    sample_ok_q |-> frame_qualified_q && !order_mismatch_q && $past(safing_mode))
    else $error("sample_ok without its conditions");
  qual_pulse_a: assert property (
    frame_qualified_q |=> !frame_qualified_q [*8]) else $error("frame pulse too long");
  count_step_a: assert property (
    sample_ok_q && valid_count_q != 4'h1 |-> valid_count_q == $past(valid_count_q) + 4'h1)
    else $error("count did not step by one");
  count_hold_a: assert property (
    !sample_ok_q && valid_count_q != 4'h0 |-> $stable(valid_count_q)) else $error("count moved");
  // Sync delay puts the clear a few cycles behind the pin
  fault_clear_a: assert property (
    $fell(order_fault_bit_q) |-> $past(period_sync, 2) || $past(period_sync, 3)
      || $past(period_sync, 4) || $past(period_sync, 5)) else $error("fault cleared early");
  write_gate_a: assert property (
    limit_wr_done_q |-> $past(limit_write_cmd) && $past(startup_mode))
    else $error("write accepted outside start-up");
  write_read_a: assert property (
    limit_wr_done_q && $stable(limit_index) |=> limit_rd_q == $past(cmd_data, 2))
    else $error("written limit not read back");
  buffer_hold_a: assert property (
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data)) else $error("word lost");

  cover property (frame_qualified_q);
  cover property (order_mismatch_q);
  cover property (sample_drop_q);
endmodule
`default_nettype wire

// File: tb/ssf_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_spi_host (
  output logic       sck,  // Serial clock, low outside frames
  output logic       miso, // Reply data
  output logic [3:0] cs_n  // Selects, active low
);
  initial begin
    sck = 1'b0;
    miso = 1'b1;
    cs_n = 4'hF;
  end
  // Mode 0, MSB first; bits past sixteen toggle
  task automatic frame(input logic [3:0] sel, input logic [15:0] w, input int nb);
    #37 cs_n = ~sel;
    for (int i = 0; i < nb; i++) begin
      miso = (i < 16) ? w[15 - i] : ~miso;
      #400 sck = 1'b1;
      #400 sck = 1'b0;
    end
    #400 cs_n = 4'hF;
    // Released line shows the inverse, never a stale bit
    miso = ~miso;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb;
  logic        core_clk, srst = 1'b1, safing_mode = 1'b0, startup_mode = 1'b0;
  logic        period_sync = 1'b0, smp_ready = 1'b0, fault_n = 1'b0;
  logic        limit_key_cmd = 1'b0, limit_write_cmd = 1'b0, other_cmd = 1'b0;
  logic [7:0]  cmd_data = 8'h00;
  logic [2:0]  limit_index = 3'h0;
  logic [3:0]  cnt_n = 4'h0;
  logic [16:0] seed = 17'h10EAB;
  logic [63:0] lim = 64'h040408080808950D;
  logic [13:0] expq[$];
  int          err_count = 0, n_tests = 0, ord_n = -1, drops = 0;
  wire         spi_sck, spi_miso, frame_qualified_q, order_mismatch_q, order_fault_bit_q;
  wire         sample_ok_q, cmp_dwell_long_q, limit_wr_done_q, sample_drop_q, buf_ready;
  wire         smp_valid;
  wire  [3:0]  cs_n, valid_count_q;
  wire  [7:0]  limit_rd_q;
  wire  [8:0]  cmp_limit_q;
  wire  [13:0] smp_data;

  ssf_spi_host host (.sck(spi_sck), .miso(spi_miso), .cs_n(cs_n));
  ssf_monitor dut (.core_clk, .srst, .safing_mode, .startup_mode, .spi_sck, .spi_miso,
    .cs_main_n(cs_n[0]), .onboard_pick_one_n(cs_n[1]), .onboard_pick_two_n(cs_n[2]),
    .expansion_pick_three_n(cs_n[3]), .period_sync, .limit_key_cmd, .limit_write_cmd,
    .other_cmd, .cmd_data, .limit_index, .smp_ready, .frame_qualified_q, .order_mismatch_q,
    .order_fault_bit_q, .sample_ok_q, .valid_count_q, .cmp_limit_q, .cmp_dwell_long_q,
    .limit_rd_q, .limit_wr_done_q, .sample_drop_q, .buf_ready, .smp_valid, .smp_data);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return seed[15:0];
  endfunction
  function automatic logic in_rng(input logic [9:0] v, input int o);
    return o < 3 || ($signed(v) >= -480 && $signed(v) <= 480);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmd(input int k, input logic [7:0] d);
    cmd_data = d;
    limit_key_cmd = (k == 0);
    limit_write_cmd = (k == 1);
    other_cmd = (k == 2);
    tick(1);
    limit_key_cmd = 1'b0;
    limit_write_cmd = 1'b0;
    other_cmd = 1'b0;
  endtask
  task automatic chk_lims();
    for (int i = 0; i < 8; i++) begin
      limit_index = i[2:0];
      tick(2);
      `CHK("limit", lim[i*8 +: 8], limit_rd_q)
    end
  endtask
  task automatic psync();
    period_sync = 1'b1;
    tick(4);
    period_sync = 1'b0;
    tick(6);
    ord_n = -1;
    fault_n = 1'b0;
    cnt_n = 4'h0;
    `CHK("count", cnt_n, valid_count_q)
  endtask
  task automatic snoop(input logic [3:0] sel, input logic [15:0] w, input int nb);
    logic q, m, o, qe, me, oe;
    q = 1'b0;
    m = 1'b0;
    o = 1'b0;
    host.frame(sel, w, nb);
    repeat (12) begin
      tick(1);
      q |= frame_qualified_q;
      m |= order_mismatch_q;
      o |= sample_ok_q;
      drops += sample_drop_q;
    end
    qe = nb >= 16 && $onehot(sel) && safing_mode && ord_n != 14;
    ord_n += qe;
    me = qe && w[13:11] != ord_n[2:0];
    oe = qe && !me && !fault_n && w[15:14] == 2'h1 && in_rng(w[9:0], ord_n);
    fault_n |= me;
    cnt_n += oe;
    if (oe) expq.push_back({ord_n[3:0], w[9:0]});
    `CHK("qualified", qe, q)
    `CHK("mismatch", me, m)
    `CHK("sample_ok", oe, o)
    `CHK("count", cnt_n, valid_count_q)
    `CHK("fault", fault_n, order_fault_bit_q)
    if (oe) `CHK("cmp", {lim[ord_n[3:1]*8 + 7], 2'h0, lim[ord_n[3:1]*8 +: 7]}, {cmp_dwell_long_q, cmp_limit_q})
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    logic [15:0] r, w;
    logic [13:0] x;
    logic [3:0]  sel;
    int          nb;
    tick(3);
    srst = 1'b0;
    chk_lims();
    limit_index = 3'h3;
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      startup_mode = (i != 3);
      cmd(0, r[7:0]);
      if (i == 1) cmd(2, 8'h00);
      cmd(1, r[7:0] ^ ((i == 2) ? 8'hAE : 8'hAD));
      `CHK("wr_done", i == 0, limit_wr_done_q)
      if (i == 0) lim[24 +: 8] = r[7:0] ^ 8'hAD;
    end
    startup_mode = 1'b0;
    chk_lims();
    for (int p = 0; p < 2; p++) begin
      psync();
      for (int k = 0; k < 17; k++) begin
        r = rnd();
        sel = 4'h1 << (k % 4);
        nb = (p == 0 && k == 3) ? 15 : (p == 0 && k == 4) ? 17 : 16;
        if (p == 0 && k == 5) sel |= 4'h8;
        safing_mode = !(p == 0 && k == 6);
        w = {(r[3:0] == 4'h0) ? r[5:4] : 2'h1, 3'(ord_n + 1), r[10:0]};
        if (p == 1 && k == 12) w[11] = ~w[11];
        if (k == 1) w[9:0] = 10'h200;
        if (k == 7) w[9:0] = 10'h1E0;
        if (k == 8) w[9:0] = 10'h21F;
        snoop(sel, w, nb);
      end
    end
    `CHK("buf_ready", expq.size() < 17, buf_ready)
    smp_ready = 1'b1;
    repeat (40) begin
      if (smp_valid === 1'b1 && expq.size() > 0) begin
        x = expq.pop_front();
        `CHK("sample", x, smp_data)
      end
      tick(1);
    end
    `CHK("drops", expq.size(), drops)
    tally_and_finish();
  end

  initial begin
    #3000000;
    err_count++;
    tally_and_finish();
  end
endmodule
bind ssf_monitor ssf_monitor_props u_props (.core_clk, .srst, .safing_mode, .startup_mode,
  .period_sync, .limit_write_cmd, .cmd_data, .limit_index, .smp_ready, .frame_qualified_q,
  .order_mismatch_q, .order_fault_bit_q, .sample_ok_q, .valid_count_q, .limit_rd_q,
  .limit_wr_done_q, .sample_drop_q, .smp_valid, .smp_data);
`default_nettype wire
